// >>> srl_loader.sv
// Purpose: Serial ROM configuration loader with checksum, errors and a byte access port.
// Assumes: Register bus is AXI4-Lite; the switch register space answers cfg_addr_mapped.
// Notes: One bus transaction at a time, shared by the loader and the access port.
`timescale 1ns/1ps
`default_nettype none
module srl_loader (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic aclk_en,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic load_req,
  input wire logic [3:0] rom_addr_strap,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic cfg_wr_en,
  output logic [13:0] cfg_addr,
  output logic [31:0] cfg_wdata,
  input wire logic cfg_addr_mapped,
  output logic hold_after_reset,
  output logic load_active
);
  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_START = 4'h1,
    S_DEVW = 4'h3,
    S_AHI = 4'h2,
    S_ALO = 4'h6,
    S_WDAT = 4'h7,
    S_RSTART = 4'h5,
    S_DEVR = 4'h4,
    S_RD = 4'hc,
    S_ACK = 4'hd,
    S_STOP = 4'hf
  } srl_seq_t;
  typedef enum logic [2:0] {
    P_A0 = 3'h0,
    P_A1 = 3'h1,
    P_N0 = 3'h3,
    P_N1 = 3'h2,
    P_D = 3'h6
  } srl_parse_t;

  srl_seq_t st;
  srl_parse_t ph;
  srl_pkg::srl_ecmd_t e_cmd;
  srl_pkg::srl_blk_t typ;
  logic [8:0] e_tx;
  logic [3:0] e_n;
  logic e_chk;
  logic eng_go;
  logic eng_busy;
  logic eng_done;
  logic [8:0] eng_rx;
  logic eng_arb;
  logic eng_ferr;
  logic pending;
  logic loading;
  logic ld_want;
  logic last;
  logic [4:0] arb_cnt;
  logic [15:0] rom_addr;
  logic [15:0] cur_addr;
  logic [3:0] strap_r;
  logic [7:0] rb;
  logic port_busy;
  logic port_done;
  logic port_kind;
  logic [15:0] port_addr;
  logic [7:0] port_data;
  logic [3:0] err_set;
  logic fin_set;
  logic hold_set;
  logic unm_set;
  logic op_end;
  logic wstate;
  logic [7:0] sum;
  logic [7:0] sum_new;
  logic [15:0] cnt;
  logic [1:0] bcnt;
  logic [23:0] dat;
  logic wr_pend;
  logic at_type;
  logic cs_bad;
  logic ld_last;
  logic rd_ok;
  logic skip_sum_check;
  logic [5:0] stat;
  logic aw_full;
  logic w_full;
  logic [7:0] aw_a;
  logic [31:0] w_d;
  logic [3:0] w_s;
  logic wr_do;
  logic port_wr;
  logic port_go;

  srl_bus_engine u_engine (
    .aclk(aclk),
    .aresetn(aresetn),
    .aclk_en(aclk_en),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .scl_o(scl_o),
    .scl_oe(scl_oe),
    .sda_o(sda_o),
    .sda_oe(sda_oe),
    .go(eng_go),
    .cmd(e_cmd),
    .tx(e_tx),
    .nbits(e_n),
    .chk(e_chk),
    .busy(eng_busy),
    .done(eng_done),
    .rx(eng_rx),
    .arb_lost(eng_arb),
    .frame_err(eng_ferr)
  );

  ////////////////////////////////////////////////////////////////////////////
  assign rb = eng_rx[7:0];
  assign cur_addr = loading ? rom_addr : port_addr;
  assign eng_go = (st != S_IDLE) && !pending && !eng_busy;
  assign wstate = (st == S_DEVW) || (st == S_AHI) || (st == S_ALO) || (st == S_WDAT)
    || (st == S_DEVR);
  assign op_end = eng_done && (eng_arb ? (arb_cnt == srl_pkg::ARB_MAX - 5'h01)
    : (eng_ferr || st == S_STOP));
  assign load_active = loading;

  always_comb
  begin
    e_cmd = srl_pkg::E_BITS;
    e_tx = 9'h1ff;
    e_n = 4'h9;
    e_chk = 1'b1;
    unique case (st)
      S_START, S_RSTART: e_cmd = srl_pkg::E_START;
      S_STOP, S_IDLE: e_cmd = srl_pkg::E_STOP;
      S_DEVW: e_tx = {srl_pkg::ROM_DEV_HI, strap_r, 2'b01};
      S_DEVR: e_tx = {srl_pkg::ROM_DEV_HI, strap_r, 2'b11};
      S_AHI: e_tx = {cur_addr[15:8], 1'b1};
      S_ALO: e_tx = {cur_addr[7:0], 1'b1};
      S_WDAT: e_tx = {port_data, 1'b1};
      S_RD:
      begin
        e_n = 4'h8;
        e_chk = 1'b0;
      end
      S_ACK:
      begin
        e_tx = {last, 8'hff};
        e_n = 4'h1;
        e_chk = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Parser view of the byte just read while loading.
  assign typ = srl_pkg::srl_blk_t'(rb[7:6]);
  assign at_type = (ph == P_A1);
  assign sum_new = sum + rb;
  assign cs_bad = at_type && ((typ == srl_pkg::BLK_BAD)
    || (typ == srl_pkg::BLK_DONE && sum_new != srl_pkg::SUM_GOOD && !skip_sum_check));
  assign ld_last = (at_type && (typ == srl_pkg::BLK_DONE || typ == srl_pkg::BLK_BAD))
    || rom_addr == srl_pkg::ROM_TOP;
  assign rd_ok = eng_done && st == S_RD && !eng_arb && !eng_ferr && loading;
  assign cfg_wr_en = wr_pend && cfg_addr_mapped;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ph <= P_A0;
      sum <= 8'h00;
      cnt <= 16'h0000;
      bcnt <= 2'h0;
      dat <= 24'h000000;
      wr_pend <= 1'b0;
      unm_set <= 1'b0;
      cfg_addr <= 14'h0000;
      cfg_wdata <= 32'h00000000;
    end
    else if (aclk_en)
    begin
      unm_set <= 1'b0;
      if (wr_pend)
      begin
        wr_pend <= 1'b0;
        unm_set <= !cfg_addr_mapped;
        cfg_addr <= cfg_addr + 14'h0001;
      end
      if (st == S_IDLE && ld_want && !port_busy)
      begin
        ph <= P_A0;
        sum <= 8'h00;
      end
      else if (rd_ok)
      begin
        sum <= sum_new;
        unique case (ph)
          P_A0:
          begin
            cfg_addr[7:0] <= rb;
            ph <= P_A1;
          end
          P_A1:
          begin
            cfg_addr[13:8] <= rb[5:0];
            bcnt <= 2'h0;
            cnt <= 16'h0001;
            // Type 0 carries one word, type 1 a count; done ends the load.
            if (typ == srl_pkg::BLK_SINGLE)
              ph <= P_D;
            else if (typ == srl_pkg::BLK_SEQ)
              ph <= P_N0;
            else
              ph <= P_A0;
          end
          P_N0:
          begin
            cnt[7:0] <= rb;
            ph <= P_N1;
          end
          P_N1:
          begin
            cnt[15:8] <= rb;
            ph <= ({rb, cnt[7:0]} == 16'h0000) ? P_A0 : P_D;
          end
          P_D:
          begin
            dat <= {rb, dat[23:8]};
            bcnt <= bcnt + 2'h1;
            if (bcnt == 2'h3)
            begin
              cfg_wdata <= {rb, dat};
              wr_pend <= 1'b1;
              cnt <= cnt - 16'h0001;
              if (cnt == 16'h0001)
                ph <= P_A0;
            end
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st <= S_IDLE;
      pending <= 1'b0;
      loading <= 1'b0;
      ld_want <= 1'b0;
      last <= 1'b0;
      arb_cnt <= 5'h00;
      rom_addr <= 16'h0000;
      strap_r <= 4'h0;
      port_busy <= 1'b0;
      port_done <= 1'b0;
      port_kind <= 1'b0;
      port_addr <= 16'h0000;
      port_data <= 8'h00;
      err_set <= 4'h0;
      fin_set <= 1'b0;
      hold_set <= 1'b0;
    end
    else if (aclk_en)
    begin
      err_set <= 4'h0;
      fin_set <= 1'b0;
      hold_set <= 1'b0;
      if (load_req)
        ld_want <= 1'b1;
      if (eng_go)
        pending <= 1'b1;
      if (port_wr && !port_busy && !loading)
      begin
        if (w_s[1])
          port_addr[7:0] <= w_d[15:8];
        if (w_s[2])
          port_addr[15:8] <= w_d[23:16];
        if (w_s[3])
          port_kind <= w_d[srl_pkg::PORT_KIND_BIT];
      end
      if (port_go)
      begin
        port_busy <= 1'b1;
        port_done <= 1'b0;
        port_data <= w_d[7:0];
      end
      if (st == S_IDLE)
      begin
        arb_cnt <= 5'h00;
        last <= 1'b0;
        if (ld_want && !port_busy)
        begin
          ld_want <= 1'b0;
          loading <= 1'b1;
          rom_addr <= 16'h0000;
          strap_r <= rom_addr_strap;
          st <= S_START;
        end
        else if (port_busy)
          st <= S_START;
      end
      else if (eng_done)
      begin
        pending <= 1'b0;
        if (eng_arb)
        begin
          // Lost bus: retry the transaction from the current byte.
          arb_cnt <= arb_cnt + 5'h01;
          if (arb_cnt == srl_pkg::ARB_MAX - 5'h01)
          begin
            err_set[srl_pkg::ERR_LA] <= 1'b1;
            hold_set <= loading;
            st <= S_IDLE;
          end
          else
            st <= S_START;
        end
        else if (eng_ferr)
        begin
          err_set[srl_pkg::ERR_OTH] <= 1'b1;
          hold_set <= loading;
          st <= S_IDLE;
        end
        else if (wstate && eng_rx[0])
        begin
          err_set[srl_pkg::ERR_NA] <= 1'b1;
          hold_set <= loading;
          st <= S_STOP;
        end
        else
        begin
          if (wstate)
            arb_cnt <= 5'h00;
          unique case (st)
            S_START: st <= S_DEVW;
            S_DEVW: st <= S_AHI;
            S_AHI: st <= S_ALO;
            S_ALO: st <= (!loading && port_kind) ? S_WDAT : S_RSTART;
            S_WDAT: st <= S_STOP;
            S_RSTART: st <= S_DEVR;
            S_DEVR: st <= S_RD;
            S_RD:
            begin
              if (loading)
              begin
                rom_addr <= rom_addr + 16'h0001;
                last <= ld_last || cs_bad;
                err_set[srl_pkg::ERR_CS] <= cs_bad;
                hold_set <= cs_bad;
              end
              else
              begin
                port_data <= rb;
                last <= 1'b1;
              end
              st <= S_ACK;
            end
            S_ACK: st <= last ? S_STOP : S_RD;
            S_STOP: st <= S_IDLE;
            default: st <= S_IDLE;
          endcase
        end
      end
      if (op_end)
      begin
        if (loading)
        begin
          loading <= 1'b0;
          fin_set <= 1'b1;
        end
        else
        begin
          port_busy <= 1'b0;
          port_done <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Hardware sets win over software clears in the same cycle.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stat <= srl_pkg::RST_STAT;
      hold_after_reset <= 1'b0;
      skip_sum_check <= 1'b0;
    end
    else if (aclk_en)
    begin
      if (wr_do && aw_a == srl_pkg::OFF_STAT && w_s[0])
        stat <= (stat & ~w_d[5:0]) | {unm_set, err_set, fin_set};
      else
        stat <= stat | {unm_set, err_set, fin_set};
      if (wr_do && aw_a == srl_pkg::OFF_SWITCH_CONTROL_REG && w_s[0])
        hold_after_reset <= w_d[0] | hold_set;
      else if (hold_set)
        hold_after_reset <= 1'b1;
      if (wr_do && aw_a == srl_pkg::OFF_CTRL && w_s[0])
        skip_sum_check <= w_d[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign s_axi_awready = !aw_full;
  assign s_axi_wready = !w_full;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_do = aw_full && w_full && !s_axi_bvalid;
  assign port_wr = wr_do && aw_a == srl_pkg::OFF_PORT;
  assign port_go = port_wr && w_s[0] && !port_busy && !loading;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_a <= 8'h00;
      w_d <= 32'h00000000;
      w_s <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= srl_pkg::RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= srl_pkg::RESP_OKAY;
    end
    else if (aclk_en)
    begin
      if (s_axi_awvalid && !aw_full)
      begin
        aw_full <= 1'b1;
        aw_a <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && !w_full)
      begin
        w_full <= 1'b1;
        w_d <= s_axi_wdata;
        w_s <= s_axi_wstrb;
      end
      if (wr_do)
      begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_a <= srl_pkg::OFF_PORT) ? srl_pkg::RESP_OKAY : srl_pkg::RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (s_axi_arvalid && !s_axi_rvalid)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= srl_pkg::RESP_OKAY;
        unique case ({s_axi_araddr[7:2], 2'b00})
          srl_pkg::OFF_CTRL: s_axi_rdata <= {31'h0, skip_sum_check};
          srl_pkg::OFF_SWITCH_CONTROL_REG: s_axi_rdata <= {31'h0, hold_after_reset};
          srl_pkg::OFF_STAT: s_axi_rdata <= {26'h0, stat};
          srl_pkg::OFF_PORT: s_axi_rdata <= {port_done, port_busy || loading, 5'h0,
            port_kind, port_addr, port_data};
          srl_pkg::OFF_ALIAS: s_axi_rdata <= {31'h0, stat[srl_pkg::ST_FIN]};
          default:
          begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= srl_pkg::RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule : srl_loader
`default_nettype wire

// >>> srl_pkg.sv
// Purpose: Shared constants and types of the serial ROM configuration loader.
// Assumes: 100 MHz aclk, AXI4-Lite register slave, open-drain two-wire master bus.
// Notes: Offsets are byte addresses on the register bus.
package srl_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int BUS_PERIOD_NS = 2500;
  localparam int QTR_CYC = (BUS_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
  localparam logic [7:0] QTR_LAST = 8'(QTR_CYC - 1);
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_SWITCH_CONTROL_REG = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_PORT = 8'h0c;
  localparam logic [7:0] OFF_ALIAS = 8'h10;
  localparam int ST_FIN = 0;
  localparam int ST_CS = 1;
  localparam int ST_UNM = 5;
  localparam int ERR_CS = 0;
  localparam int ERR_NA = 1;
  localparam int ERR_LA = 2;
  localparam int ERR_OTH = 3;
  localparam int PORT_KIND_BIT = 24;
  localparam int PORT_BUSY_BIT = 30;
  localparam int PORT_DONE_BIT = 31;
  localparam logic [5:0] RST_STAT = 6'h00;
  localparam logic [4:0] ARB_MAX = 5'h10;
  localparam logic [2:0] ROM_DEV_HI = 3'h5;
  localparam logic [7:0] SUM_GOOD = 8'hff;
  localparam logic [15:0] ROM_TOP = 16'hffff;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    BLK_SINGLE = 2'h0,
    BLK_SEQ = 2'h1,
    BLK_BAD = 2'h2,
    BLK_DONE = 2'h3
  } srl_blk_t;
  typedef enum logic [1:0] {
    E_START = 2'h0,
    E_STOP = 2'h1,
    E_BITS = 2'h3
  } srl_ecmd_t;
endpackage : srl_pkg

// >>> srl_bus_engine.sv
// Purpose: Bit level engine of the two-wire master bus: start, stop, bit groups.
// Assumes: Open-drain lines; oe high pulls the line low.
// Notes: Waits for a stretched clock before each high-phase sample.
`timescale 1ns/1ps
`default_nettype none
module srl_bus_engine (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic aclk_en,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic scl_oe,
  output logic sda_o,
  output logic sda_oe,
  input wire logic go,
  input wire srl_pkg::srl_ecmd_t cmd,
  input wire logic [8:0] tx,
  input wire logic [3:0] nbits,
  input wire logic chk,
  output logic busy,
  output logic done,
  output logic [8:0] rx,
  output logic arb_lost,
  output logic frame_err
);
  logic [2:0] scl_s;
  logic [2:0] sda_s;
  logic scl_f;
  logic sda_f;
  logic scl_p;
  logic sda_p;
  logic chk_r;
  logic [1:0] q;
  logic [7:0] tmr;
  logic [3:0] left;
  logic [8:0] sh;
  srl_pkg::srl_ecmd_t c;
  logic bus_cond;

  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  // A data change while the clock is high is a start or stop condition.
  assign bus_cond = scl_f && scl_p && (sda_f != sda_p);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
      scl_f <= 1'b1;
      sda_f <= 1'b1;
      scl_p <= 1'b1;
      sda_p <= 1'b1;
    end
    else if (aclk_en)
    begin
      scl_s <= {scl_s[1:0], scl_i};
      sda_s <= {sda_s[1:0], sda_i};
      if (scl_s[2] == scl_s[1])
        scl_f <= scl_s[2];
      if (sda_s[2] == sda_s[1])
        sda_f <= sda_s[2];
      scl_p <= scl_f;
      sda_p <= sda_f;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      busy <= 1'b0;
      done <= 1'b0;
      q <= 2'h0;
      tmr <= 8'h00;
      left <= 4'h0;
      sh <= 9'h000;
      rx <= 9'h000;
      c <= srl_pkg::E_STOP;
      chk_r <= 1'b0;
      arb_lost <= 1'b0;
      frame_err <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end
    else if (aclk_en)
    begin
      done <= 1'b0;
      if (!busy)
      begin
        if (go)
        begin
          busy <= 1'b1;
          c <= cmd;
          sh <= tx;
          left <= nbits;
          chk_r <= chk;
          q <= 2'h0;
          tmr <= 8'h00;
          rx <= 9'h000;
          arb_lost <= 1'b0;
          frame_err <= 1'b0;
        end
      end
      else if (c == srl_pkg::E_BITS && bus_cond)
      begin
        frame_err <= 1'b1;
        busy <= 1'b0;
        done <= 1'b1;
        scl_oe <= 1'b0;
        sda_oe <= 1'b0;
      end
      else if (q == 2'h2 && !scl_f)
        tmr <= 8'h00;
      else if (tmr != srl_pkg::QTR_LAST)
        tmr <= tmr + 8'h01;
      else
      begin
        tmr <= 8'h00;
        q <= q + 2'h1;
        unique case (c)
          srl_pkg::E_BITS:
            unique case (q)
              2'h0: sda_oe <= !sh[8];
              2'h1: scl_oe <= 1'b0;
              2'h2:
              begin
                rx <= {rx[7:0], sda_f};
                // Another master pulled a bit low that this end released.
                if (chk_r && left != 4'h1 && sh[8] && !sda_f)
                begin
                  arb_lost <= 1'b1;
                  busy <= 1'b0;
                  done <= 1'b1;
                  sda_oe <= 1'b0;
                end
              end
              2'h3:
              begin
                scl_oe <= 1'b1;
                sh <= {sh[7:0], 1'b1};
                left <= left - 4'h1;
                if (left == 4'h1)
                begin
                  busy <= 1'b0;
                  done <= 1'b1;
                end
              end
            endcase
          srl_pkg::E_START:
            unique case (q)
              2'h0:
              begin
                sda_oe <= 1'b0;
                scl_oe <= 1'b0;
              end
              2'h1: sda_oe <= 1'b0;
              2'h2:
                if (!sda_f)
                begin
                  arb_lost <= 1'b1;
                  busy <= 1'b0;
                  done <= 1'b1;
                end
                else
                  sda_oe <= 1'b1;
              2'h3:
              begin
                scl_oe <= 1'b1;
                busy <= 1'b0;
                done <= 1'b1;
              end
            endcase
          srl_pkg::E_STOP:
            unique case (q)
              2'h0: sda_oe <= 1'b1;
              2'h1: scl_oe <= 1'b0;
              2'h2: sda_oe <= 1'b0;
              2'h3:
              begin
                busy <= 1'b0;
                done <= 1'b1;
              end
            endcase
        endcase
      end
    end
  end
endmodule : srl_bus_engine
`default_nettype wire

// >>> srl_assertions.sv
// Purpose: Port checker of the ROM loader.
// Assumes: One clock domain.
// Notes: Bound at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
module srl_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cfg_wr_en,
  input wire logic cfg_addr_mapped,
  input wire logic hold_after_reset,
  input wire logic load_active
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_one_pulse;
    cfg_wr_en ##1 !cfg_wr_en [*8];
  endsequence
  AST_WR_ANSWER: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("late write response");
  AST_B_ONCE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("late read data");
  AST_R_ONCE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  AST_CFG_MAPPED: assert property (cfg_wr_en |-> cfg_addr_mapped && load_active)
    else $error("config write outside a mapped load");
  AST_CFG_PULSE: assert property (cfg_wr_en |-> s_one_pulse)
    else $error("config write too long");
  // A checksum abort still ends with the closing acknowledge bit and a stop, so allow 1000 cycles, about four bus bits.
  AST_HOLD_ABORT: assert property ($rose(hold_after_reset) && $past(load_active)
    |-> ##[0:1000] !load_active) else $error("load kept running after error");
  AST_HOLD_KEEP: assert property ($fell(hold_after_reset)
    |-> s_axi_bvalid || $past(s_axi_bvalid)) else $error("hold lost without a write");
endmodule : srl_chk
bind srl_loader srl_chk chk_u (.*);
`default_nettype wire

// >>> srl_rom_model.sv
// Purpose: Two-wire serial ROM on the loader's pins.
// Assumes: Lines pulled up; pull high drives data low.
// Notes: No clock stretching; 256 bytes, so addresses wrap.
`timescale 1ns/1ps
`default_nettype none
module srl_rom_model #(parameter logic [3:0] STRAP = 4'h3) (
  input wire logic scl,
  input wire logic sda,
  output logic pull
);
  logic [7:0] mem [0:255];
  logic [7:0] sh;
  logic [15:0] ptr;
  int n = 0;
  int st = 0;
  initial pull = 1'b0;
  always @(negedge sda)
  begin
    if (scl) n = 0;
    if (scl) st = 1;
  end
  always @(posedge sda) if (scl) st = 0;
  always @(posedge scl)
  begin
    sh = {sh[6:0], sda};
    n = n + 1;
    if (st == 5 && n == 9 && sda) st = 0;
    else if (st == 5 && n == 9) ptr = ptr + 16'h1;
  end
  // Data only moves while the clock is low, so no false start or stop is made.
  always @(negedge scl)
  begin
    pull = 1'b0;
    if (n == 8 && st > 0 && st < 5)
    begin
      pull = st > 1 || sh[7:1] == {3'h5, STRAP};
      if (st == 4) mem[ptr[7:0]] = sh;
      if (st == 4) ptr = ptr + 16'h1;
      if (st == 3) ptr[7:0] = sh;
      if (st == 2) ptr[15:8] = sh;
      if (st == 1) st = !pull ? 0 : sh[0] ? 6 : 2;
      else if (st < 4) st = st + 1;
    end
    else if (n == 9)
    begin
      n = 0;
      if (st == 6) st = 5;
    end
    if (st == 5 && n < 8) pull = !mem[ptr[7:0]][7 - n];
  end
endmodule : srl_rom_model
`default_nettype wire

// >>> srl_tb.sv
// Purpose: Self-checking bench of the ROM loader.
// Assumes: aclk_en and strap tied; ROM model on the pins.
// Notes: Reads and config writes are checked from queues.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic aclk_en = 1'b1;
  logic [3:0] rom_addr_strap = 4'h3;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0, b;
  logic [31:0] s_axi_wdata = 32'h0, d, rm, re, s_axi_rdata, cfg_wdata;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0, load_req = 1'b0, cfg_addr_mapped = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, scl_o, scl_oe;
  logic sda_o, sda_oe, pull, cfg_wr_en, hold_after_reset, load_active;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [13:0] cfg_addr;
  logic [45:0] ce, cq[$];
  logic [31:0] rq_m[$], rq_e[$];
  logic [7:0] img [0:7] = '{8'h10, 8'h00, 8'h44, 8'h33, 8'h22, 8'h11, 8'h85, 8'hc0};
  int n_fail = 0, compares = 0, cyc = 0, seed = 32'ha92dd661;
  wire scl_i = !scl_oe;
  wire sda_i = !(sda_oe || pull);
  srl_loader dut_u (.*);
  srl_rom_model rom_u (.scl(scl_i), .sda(sda_i), .pull(pull));
  initial forever #5 aclk = !aclk;
  always @(posedge aclk) if (++cyc == 95000) give_verdict(1);
  always @(negedge aclk)
  begin
    if (s_axi_rvalid && s_axi_rready)
    begin
      rm = rq_m.pop_front();
      re = rq_e.pop_front();
      `CHK(s_axi_rdata & rm, re)
    end
    if (cfg_wr_en)
    begin
      ce = cq.pop_front();
      `CHK({cfg_addr, cfg_wdata}, ce)
    end
  end
  task automatic give_verdict(input int extra);
    n_fail += extra;
    if (n_fail == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict
  // Handshakes are sampled on the falling edge so the answer never races the drive.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] v,
    input logic [3:0] s, input logic [31:0] m);
    logic ta, tw, tr, t;
    @(posedge aclk);
    if (!wr) rq_m.push_back(m);
    if (!wr) rq_e.push_back(v);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= s;
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_bready <= wr;
    s_axi_arvalid <= !wr;
    s_axi_rready <= !wr;
    t = 1'b0;
    while (!t)
    begin
      @(negedge aclk);
      ta = s_axi_awready;
      tw = s_axi_wready;
      tr = s_axi_arready;
      t = s_axi_bvalid && s_axi_bready || s_axi_rvalid && s_axi_rready;
      d = s_axi_rdata;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tr) s_axi_arvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
  endtask : bus
  task automatic port(input logic k, input logic [7:0] v);
    bus(1'b1, 8'h0c, {7'h0, k, 16'h6, 8'h0}, 4'he, 32'h0);
    bus(1'b0, 8'h0c, 32'h0, 4'h0, 32'h40000000);
    bus(1'b1, 8'h0c, {24'h0, v}, 4'h1, 32'h0);
    bus(1'b0, 8'h0c, 32'h40000000, 4'h0, 32'hc0000000);
    while (d[30]) bus(1'b0, 8'h0c, 32'h0, 4'h0, 32'h0);
    bus(1'b0, 8'h0c, 32'h80000000, 4'h0, 32'hc0000000);
  endtask : port
  task automatic run_load();
    @(posedge aclk);
    load_req <= 1'b1;
    @(posedge aclk);
    load_req <= 1'b0;
    wait (load_active);
    wait (!load_active);
  endtask : run_load
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    for (int i = 0; i < 256; i++) rom_u.mem[i] = i < 8 ? img[i] : 8'hff;
    b = {1'b0, 7'($random(seed))};
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    cq.push_back({14'h10, 32'h11223344});
    run_load();
    bus(1'b0, 8'h08, 32'h01, 4'h0, 32'h3f);
    port(1'b1, b);
    port(1'b0, 8'h0);
    bus(1'b0, 8'h0c, {24'h800000, b}, 4'h0, 32'hc00000ff);
    bus(1'b0, 8'h08, 32'h0, 4'h0, 32'h3e);
    bus(1'b1, 8'h08, 32'h3f, 4'hf, 32'h0);
    cfg_addr_mapped <= 1'b0;
    run_load();
    bus(1'b0, 8'h08, 32'h23, 4'h0, 32'h3f);
    bus(1'b0, 8'h04, 32'h1, 4'h0, 32'h1);
    bus(1'b1, 8'h04, 32'h0, 4'hf, 32'h0);
    bus(1'b0, 8'h14, 32'h0, 4'h0, 32'hffffffff);
    `CHK(cq.size(), 0)
    give_verdict(0);
  end
endmodule : testbench
`default_nettype wire
